/* File: logic/nvcsu_pkg.sv */
package nvcsu_pkg;

    localparam logic [11:0] NVCSU_COMMIT_ADDR = 12'h232;
    localparam logic [11:0] NVCSU_DESC_BASE   = 12'ha00;
    localparam logic [11:0] NVCSU_DESC_LAST   = 12'ha16;
    localparam logic [11:0] NVCSU_PROG_ADDR   = 12'hb00;
    localparam logic [11:0] NVCSU_ERR_ADDR    = 12'hb01;
    localparam logic [11:0] NVCSU_CTRL_ADDR   = 12'hb02;
    localparam logic [11:0] NVCSU_STORE_ADDR  = 12'hb03;

    localparam int NVCSU_DESC_NUM = 23;
    localparam int NVCSU_COMMIT_BIT = 0;
    localparam int NVCSU_BUSY_BIT   = 0;
    localparam int NVCSU_ERR_BIT    = 0;
    localparam int NVCSU_WEN_BIT    = 0;
    localparam int NVCSU_SOFT_BIT   = 1;
    localparam int NVCSU_STORE_BIT  = 0;
    localparam int NVCSU_OP_FLAG_BIT = 7;

    localparam logic [7:0] NVCSU_OP_COMMIT = 8'h80;
    localparam logic [7:0] NVCSU_OP_END    = 8'hff;
    localparam logic       NVCSU_WEN_RESET = 1'b0;

    // Default list: five segments spanning 0x000..0x232, then commit, then end
    localparam logic [7:0] NVCSU_SEG_FULL = 8'h7f;
    localparam logic [7:0] NVCSU_SEG_TAIL = 8'h37;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } nvcsu_req_s;

    typedef enum logic [1:0] {NVCSU_SEG, NVCSU_COMMIT, NVCSU_END} nvcsu_kind_e;

    typedef struct packed {
        nvcsu_kind_e kind;
        logic [6:0]  cnt;
        logic [11:0] addr;
    } nvcsu_desc_s;

    function automatic logic [7:0] nvcsu_desc_default(input int idx);
        logic [11:0] start;
        start = 12'(((idx / 3) * 127));
        if (idx < 15) begin
            case (idx % 3)
                0:       nvcsu_desc_default = (idx == 12) ? NVCSU_SEG_TAIL : NVCSU_SEG_FULL;
                1:       nvcsu_desc_default = {4'h0, start[11:8]};
                default: nvcsu_desc_default = start[7:0];
            endcase
        end else if (idx == 15) begin
            nvcsu_desc_default = NVCSU_OP_COMMIT;
        end else begin
            nvcsu_desc_default = NVCSU_OP_END;
        end
    endfunction

endpackage

/* File: logic/nvcsu_fifo2.sv */
`timescale 1ns/10ps
`default_nettype none
module nvcsu_fifo2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             core_clk,  // Clock
    input  wire logic             reset_n,   // Async reset, active low
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word in
    output logic                  out_valid, // Word held
    input  wire logic             out_ready, // Drain accepts
    output logic      [WIDTH-1:0] out_data   // Oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    cnt_reg;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready  = (cnt_reg != CW'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= bump(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= bump(rd_ptr_reg);
            end
            if (push && !pop) begin
                cnt_reg <= CW'(cnt_reg + 1'b1);
            end else if (pop && !push) begin
                cnt_reg <= CW'(cnt_reg - 1'b1);
            end
        end
    end
endmodule // nvcsu_fifo2
`default_nettype wire

/* File: logic/nvcsu_desc_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module nvcsu_desc_decode
    import nvcsu_pkg::*;
(
    input  wire logic [7:0] head,  // Count byte or opcode
    input  wire logic [7:0] hi,    // Start address, upper nibble
    input  wire logic [7:0] lo,    // Start address, low byte
    output nvcsu_desc_s     desc   // Decoded entry
);
    always_comb begin
        desc.cnt  = head[6:0];
        desc.addr = {hi[3:0], lo};
        if (!head[NVCSU_OP_FLAG_BIT]) begin
            desc.kind = NVCSU_SEG;
        end else if (head == NVCSU_OP_COMMIT) begin
            desc.kind = NVCSU_COMMIT;
        end else begin
            // Any other flagged byte ends the list, so a corrupt list cannot run away
            desc.kind = NVCSU_END;
        end
    end
endmodule // nvcsu_desc_decode
`default_nettype wire

/* File: logic/nvcsu_core.sv */
// Function
// - Writing one to 0x232 bit 0 commits staged registers; bit self-clears.
// - Twenty-three descriptor registers at 0xA00..0xA16 hold segment addresses and counts.
// - Descriptor area also accepts commit and end-of-list opcodes.
// - Reset descriptors move all registers then commit.
// - 0xB00 bit 0 reads 1 while a transfer runs, 0 when done.
// - Transfer-pending drives the status pin when its select bit is set.
// - 0xB01 bit 0 reads 1 when bad data was seen in a transfer.
// - With boot pin low, 0xB02 bit 1 resets and reloads from nonvolatile memory.
// - The soft reload bit clears itself the cycle after its write.
// - 0xB02 bit 0 enables stores; zero at reset blocks them.
// - 0xB03 bit 0 starts a store and reads one until it ends.
`timescale 1ns/10ps
`default_nettype none
module nvcsu_core
    import nvcsu_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic        core_clk,      // Serial port clock, 20 MHz
    input  wire logic        reset_n,       // Async reset, active low
    input  wire nvcsu_req_s  reg_req,       // Register access from serial port
    output logic      [7:0]  reg_rdata,     // Read data, one cycle after rd
    input  wire logic        nv_boot_pin,   // Boot-select pin; low allows soft reload
    input  wire logic        status_sel,    // Status pin select bit from 0x01D[7]
    input  wire logic        status_alt,    // Status pin source when not selected
    output logic             status_pin,    // Status output pin
    output logic             commit_stb,    // Copy buffer to active registers
    output logic             soft_reset_stb,// Soft device reset
    output logic      [11:0] buf_rd_addr,   // Buffer bank read address
    input  wire logic [7:0]  buf_rdata,     // Buffer bank read data
    output logic             buf_wr,        // Buffer bank write strobe
    output logic      [11:0] buf_wr_addr,   // Buffer bank write address
    output logic      [7:0]  buf_wr_data,   // Buffer bank write data
    output logic             nv_store_act,  // Store in progress
    output logic             nv_wr_valid,   // Byte for nonvolatile memory
    input  wire logic        nv_wr_ready,   // Memory accepts byte
    output logic      [7:0]  nv_wr_data,    // Byte to memory
    input  wire logic        nv_wr_err,     // Memory reports a bad write
    output logic             nv_load_req,   // Load in progress, memory streams
    input  wire logic        nv_rd_valid,   // Byte from memory
    output logic             nv_rd_ready,   // Block accepts byte
    input  wire logic [7:0]  nv_rd_data,    // Byte from memory
    input  wire logic        nv_rd_err      // Byte failed its check
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_MOVE, ST_DRAIN} nvcsu_state_e;

    nvcsu_state_e state_reg;
    logic [7:0]   desc_reg [NVCSU_DESC_NUM];
    logic [4:0]   ptr_reg;
    logic         dir_reg;
    logic [11:0]  addr_reg;
    logic [11:0]  pop_addr_reg;
    logic [6:0]   left_reg;
    logic         wen_reg;
    logic         store_bit_reg;
    logic         soft_reg;
    logic         err_reg;
    logic         commit_reg;
    logic [7:0]   rdata_reg;
    logic [7:0]   rdata_next;

    nvcsu_desc_s  cur_desc;
    logic         busy;
    logic         wr_commit;
    logic         wr_desc;
    logic         wr_ctrl;
    logic         wr_store;
    logic         start_store;
    logic         start_load;
    logic         fifo_in_valid;
    logic         fifo_in_ready;
    logic [7:0]   fifo_in_data;
    logic         fifo_out_valid;
    logic         fifo_out_ready;
    logic [7:0]   fifo_out_data;
    logic         push;
    logic         pop;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
        hit = reg_req.wr && (a == base);
    endfunction

    function automatic logic [7:0] desc_at(input logic [5:0] idx);
        desc_at = (idx < 6'(NVCSU_DESC_NUM)) ? desc_reg[5'(idx)] : NVCSU_OP_END;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    assign busy        = (state_reg != ST_IDLE);
    assign wr_commit   = hit(reg_req.addr, NVCSU_COMMIT_ADDR);
    assign wr_ctrl     = hit(reg_req.addr, NVCSU_CTRL_ADDR);
    assign wr_store    = hit(reg_req.addr, NVCSU_STORE_ADDR);
    assign wr_desc     = reg_req.wr && (reg_req.addr >= NVCSU_DESC_BASE)
                         && (reg_req.addr <= NVCSU_DESC_LAST);
    // A store with protection on never starts; requests while busy are dropped
    assign start_store = wr_store && reg_req.wdata[NVCSU_STORE_BIT] && wen_reg && !busy;
    assign start_load  = wr_ctrl && reg_req.wdata[NVCSU_SOFT_BIT] && !nv_boot_pin && !busy;

    nvcsu_desc_decode u_decode (
        .head (desc_at({1'b0, ptr_reg})),
        .hi   (desc_at(6'(ptr_reg + 5'd1))),
        .lo   (desc_at(6'(ptr_reg + 5'd2))),
        .desc (cur_desc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer between the byte source and sink of either direction
    assign fifo_in_valid  = (state_reg == ST_MOVE) && (left_reg != '0)
                            && (dir_reg || nv_rd_valid);
    assign fifo_in_data   = dir_reg ? buf_rdata : nv_rd_data;
    assign fifo_out_ready = dir_reg ? nv_wr_ready : 1'b1;
    assign push           = fifo_in_valid && fifo_in_ready;
    assign pop            = fifo_out_valid && fifo_out_ready;

    nvcsu_fifo2 #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign nv_rd_ready  = !dir_reg && (state_reg == ST_MOVE) && (left_reg != '0) && fifo_in_ready;
    assign nv_wr_valid  = dir_reg && fifo_out_valid;
    assign nv_wr_data   = fifo_out_data;
    assign buf_wr       = !dir_reg && fifo_out_valid;
    assign buf_wr_addr  = pop_addr_reg;
    assign buf_wr_data  = fifo_out_data;
    assign buf_rd_addr  = addr_reg;
    assign nv_store_act = busy && dir_reg;
    assign nv_load_req  = busy && !dir_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor walk
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            ptr_reg   <= '0;
            dir_reg   <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_store || start_load) begin
                        state_reg <= ST_FETCH;
                        ptr_reg   <= '0;
                        dir_reg   <= start_store;
                    end
                end
                ST_FETCH: begin
                    case (cur_desc.kind)
                        NVCSU_SEG: begin
                            ptr_reg   <= 5'(ptr_reg + 5'd3);
                            state_reg <= ST_MOVE;
                        end
                        NVCSU_COMMIT: begin
                            ptr_reg <= 5'(ptr_reg + 5'd1);
                        end
                        default: begin
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
                ST_MOVE: begin
                    if (left_reg == '0) begin
                        state_reg <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    // Every byte of a segment lands before the next segment starts
                    if (!fifo_out_valid) begin
                        state_reg <= ST_FETCH;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Segment address and count
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg     <= '0;
            pop_addr_reg <= '0;
            left_reg     <= '0;
        end else begin
            if (state_reg == ST_FETCH && cur_desc.kind == NVCSU_SEG) begin
                addr_reg     <= cur_desc.addr;
                pop_addr_reg <= cur_desc.addr;
                left_reg     <= cur_desc.cnt;
            end else begin
                if (push) begin
                    addr_reg <= 12'(addr_reg + 12'd1);
                    left_reg <= 7'(left_reg - 7'd1);
                end
                if (pop) begin
                    pop_addr_reg <= 12'(pop_addr_reg + 12'd1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor registers; frozen while a transfer reads them
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NVCSU_DESC_NUM; i++) begin
                desc_reg[i] <= nvcsu_desc_default(i);
            end
        end else if (wr_desc && !busy) begin
            desc_reg[5'(reg_req.addr - NVCSU_DESC_BASE)] <= reg_req.wdata;
        end
    end

    // Control bits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wen_reg       <= NVCSU_WEN_RESET;
            store_bit_reg <= 1'b0;
            soft_reg      <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                wen_reg <= reg_req.wdata[NVCSU_WEN_BIT];
            end
            soft_reg <= start_load;
            if (start_store) begin
                store_bit_reg <= 1'b1;
            end else if (!busy) begin
                store_bit_reg <= 1'b0;
            end
        end
    end

    // Error flag: cleared when a transfer starts, set by any bad byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            err_reg <= 1'b0;
        end else if ((push && !dir_reg && nv_rd_err) || (pop && dir_reg && nv_wr_err)) begin
            err_reg <= 1'b1;
        end else if (start_store || start_load) begin
            err_reg <= 1'b0;
        end
    end

    // Commit strobe from the host bit or the list opcode
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            commit_reg <= 1'b0;
        end else begin
            commit_reg <= (wr_commit && reg_req.wdata[NVCSU_COMMIT_BIT])
                          || (state_reg == ST_FETCH && cur_desc.kind == NVCSU_COMMIT);
        end
    end

    assign commit_stb     = commit_reg;
    assign soft_reset_stb = soft_reg;
    assign status_pin     = status_sel ? busy : status_alt;

    ////////////////////////////////////////////////////////////////////////////////
    // Register read
    always_comb begin
        rdata_next = 8'h00;
        if (reg_req.addr >= NVCSU_DESC_BASE && reg_req.addr <= NVCSU_DESC_LAST) begin
            rdata_next = desc_reg[5'(reg_req.addr - NVCSU_DESC_BASE)];
        end else begin
            case (reg_req.addr)
                NVCSU_PROG_ADDR:  rdata_next[NVCSU_BUSY_BIT] = busy;
                NVCSU_ERR_ADDR:   rdata_next[NVCSU_ERR_BIT] = err_reg;
                NVCSU_CTRL_ADDR: begin
                    rdata_next[NVCSU_WEN_BIT]  = wen_reg;
                    rdata_next[NVCSU_SOFT_BIT] = soft_reg;
                end
                NVCSU_STORE_ADDR: rdata_next[NVCSU_STORE_BIT] = store_bit_reg;
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_req.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    AST_COMMIT_PULSE: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_commit && reg_req.wdata[NVCSU_COMMIT_BIT] |=> commit_stb)
        else $error("host commit did not pulse commit strobe");

    AST_COMMIT_SELFCLR: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(wr_commit && reg_req.wdata[NVCSU_COMMIT_BIT]) && state_reg != ST_FETCH
        |=> !commit_stb)
        else $error("commit strobe held without a cause");

    AST_DESC_STORE: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_desc && !busy |=> desc_reg[5'($past(reg_req.addr) - NVCSU_DESC_BASE)]
                             == $past(reg_req.wdata))
        else $error("descriptor write not stored");

    AST_OPCODE_COMMIT: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == ST_FETCH && cur_desc.kind == NVCSU_COMMIT
        |=> commit_stb && state_reg == ST_FETCH)
        else $error("commit opcode not executed");

    AST_BUSY_READ: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_req.rd && reg_req.addr == NVCSU_PROG_ADDR |=> reg_rdata[0] == $past(busy))
        else $error("progress bit does not follow transfer");

    AST_STATUS_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
        status_sel |-> status_pin == (nv_store_act || nv_load_req))
        else $error("status pin does not show transfer pending");

    AST_ERR_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        push && !dir_reg && nv_rd_err |=> err_reg)
        else $error("bad byte did not set error flag");

    AST_SOFT_START: assert property (@(posedge core_clk) disable iff (!reset_n)
        start_load |=> soft_reset_stb && nv_load_req)
        else $error("soft reload did not reset and load");

    AST_SOFT_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
        soft_reset_stb |=> !soft_reset_stb)
        else $error("soft reload bit did not self clear");

    AST_PROTECT: assert property (@(posedge core_clk) disable iff (!reset_n)
        !busy && !wen_reg |=> !nv_store_act)
        else $error("store started under write protection");

    AST_STORE_BIT: assert property (@(posedge core_clk) disable iff (!reset_n)
        nv_store_act ##1 (!busy && !start_store) |=> !store_bit_reg)
        else $error("store bit not cleared after store");

    AST_END_STOP: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_reg == ST_FETCH && cur_desc.kind == NVCSU_END |=> !busy)
        else $error("end opcode did not stop the transfer");

endmodule // nvcsu_core
`default_nettype wire

/* File: verification/nvcsu_nv_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nvcsu_nv_model (
    input  wire logic        core_clk,     // Clock
    input  wire logic        reset_n,      // Reset
    input  wire logic        stall,        // Slow far side
    input  wire logic [9:0]  err_at,       // Bad byte index
    input  wire logic        nv_store_act, // Store on
    input  wire logic        nv_wr_valid,  // Byte offered
    output logic             nv_wr_ready,  // Byte taken
    input  wire logic [7:0]  nv_wr_data,   // Byte in
    output logic             nv_wr_err,    // Write fault
    input  wire logic        nv_load_req,  // Load on
    output logic             nv_rd_valid,  // Byte out
    input  wire logic        nv_rd_ready,  // Byte taken
    output logic      [7:0]  nv_rd_data,   // Byte out
    output logic             nv_rd_err,    // Bad byte
    input  wire logic [11:0] buf_rd_addr,  // Bank read
    output logic      [7:0]  buf_rdata,    // Bank data
    input  wire logic        buf_wr,       // Bank write
    input  wire logic [11:0] buf_wr_addr,  // Bank address
    input  wire logic [7:0]  buf_wr_data   // Bank data
);
    logic [7:0] mem [0:1023];
    logic [7:0] bank [0:4095];
    logic [9:0] wp;
    logic [9:0] rp;
    logic [7:0] last;
    initial begin
        for (int i = 0; i < 4096; i++) bank[i] = 8'(i * 7 + 3);
        for (int i = 0; i < 1024; i++) mem[i] = 8'h5a;
    end
    assign buf_rdata = bank[buf_rd_addr];
    assign nv_wr_ready = ~stall;
    assign nv_wr_err = 1'b0;
    assign nv_rd_valid = nv_load_req & ~stall;
    // Idle data line shows the inverse of the last byte, never a stale copy
    assign nv_rd_data = nv_rd_valid ? mem[rp] : ~last;
    assign nv_rd_err = nv_rd_valid && (rp == err_at);
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp <= '0;
            rp <= '0;
            last <= 8'h00;
        end else begin
            if (!nv_store_act) wp <= '0;
            else if (nv_wr_valid && nv_wr_ready) begin
                mem[wp] <= nv_wr_data;
                wp <= wp + 10'h001;
            end
            if (!nv_load_req) rp <= '0;
            else if (nv_rd_valid && nv_rd_ready) begin
                rp <= rp + 10'h001;
                last <= mem[rp];
            end
            if (buf_wr) bank[buf_wr_addr] <= buf_wr_data;
        end
    end
endmodule // nvcsu_nv_model
`default_nettype wire

/* File: verification/test_nvcsu_core.sv */
`timescale 1ns/10ps
`default_nettype none
module test_nvcsu_core
    import nvcsu_pkg::*;
;
    logic core_clk, reset_n, nv_boot_pin, status_sel, status_alt, status_pin, commit_stb;
    logic soft_reset_stb, buf_wr, nv_store_act, nv_wr_valid, nv_wr_ready, nv_wr_err;
    logic nv_load_req, nv_rd_valid, nv_rd_ready, nv_rd_err, stall;
    logic [7:0] reg_rdata, buf_rdata, buf_wr_data, nv_wr_data, nv_rd_data;
    logic [11:0] buf_rd_addr, buf_wr_addr;
    logic [9:0] err_at;
    nvcsu_req_s reg_req;
    int fail_count, n_checks, n_commit, cyc;
    logic [7:0] dsc [5] = '{8'h05, 8'h00, 8'h10, 8'h80, 8'hff};
    nvcsu_core #(.BUF_DEPTH(2)) u_nvcsu_core (.core_clk, .reset_n, .reg_req, .reg_rdata,
        .nv_boot_pin, .status_sel, .status_alt, .status_pin, .commit_stb, .soft_reset_stb,
        .buf_rd_addr, .buf_rdata, .buf_wr, .buf_wr_addr, .buf_wr_data, .nv_store_act,
        .nv_wr_valid, .nv_wr_ready, .nv_wr_data, .nv_wr_err, .nv_load_req, .nv_rd_valid,
        .nv_rd_ready, .nv_rd_data, .nv_rd_err);
    nvcsu_nv_model u_nvcsu_nv_model (.core_clk, .reset_n, .stall, .err_at, .nv_store_act,
        .nv_wr_valid, .nv_wr_ready, .nv_wr_data, .nv_wr_err, .nv_load_req, .nv_rd_valid,
        .nv_rd_ready, .nv_rd_data, .nv_rd_err, .buf_rd_addr, .buf_rdata, .buf_wr,
        .buf_wr_addr, .buf_wr_data);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic end_sim;
        $display("Checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    // Expected reset list: five segments, a commit, then end codes
    function automatic logic [7:0] exp_desc(input int i);
        logic [11:0] s;
        s = 12'(i / 3 * 127);
        if (i > 15) return 8'hff;
        if (i == 15) return 8'h80;
        if (i % 3 == 1) return {4'h0, s[11:8]};
        if (i % 3 == 2) return s[7:0];
        return (i == 12) ? 8'h37 : 8'h7f;
    endfunction
    always @(posedge core_clk) begin
        cyc++;
        if (commit_stb === 1'b1) n_commit++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        reset_n = 1'b0;
        reg_req = '0;
        nv_boot_pin = 1'b1;
        status_sel = 1'b1;
        status_alt = 1'b0;
        stall = 1'b0;
        err_at = 10'h3ff;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 23; i++) rd(NVCSU_DESC_BASE + 12'(i), exp_desc(i));
        rd(12'hb00, 8'h00);
        rd(12'hb01, 8'h00);
        rd(12'hb02, 8'h00);
        rd(12'hfff, 8'h00);
        wr(12'h232, 8'h01);
        chk("commit_stb", 8'h01, commit_stb);
        @(posedge core_clk);
        #1 chk("commit_stb", 8'h00, commit_stb);
        wr(12'hb03, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 chk("nv_store_act", 8'h00, nv_store_act);
        wr(12'hb02, 8'h03);
        chk("soft_reset_stb", 8'h00, soft_reset_stb);
        rd(12'hb02, 8'h01);
        for (int i = 0; i < 5; i++) wr(NVCSU_DESC_BASE + 12'(i), dsc[i]);
        for (int i = 0; i < 5; i++) rd(NVCSU_DESC_BASE + 12'(i), dsc[i]);
        // Far side stalls first so the store is seen running and the buffer fills
        stall <= 1'b1;
        n_commit = 0;
        wr(12'hb03, 8'h01);
        rd(12'hb00, 8'h01);
        rd(12'hb03, 8'h01);
        chk("status_pin", 8'h01, status_pin);
        status_sel <= 1'b0;
        #1 chk("status_pin", 8'h00, status_pin);
        status_sel <= 1'b1;
        stall <= 1'b0;
        for (int i = 0; i < 3000 && nv_store_act !== 1'b0; i++) @(posedge core_clk);
        #1 chk("nv_store_act", 8'h00, nv_store_act);
        chk("n_commit", 8'h01, 8'(n_commit));
        for (int i = 0; i < 6; i++) chk("nv mem", (i < 5) ? 8'((16 + i) * 7 + 3) : 8'h5a, u_nvcsu_nv_model.mem[i]);
        rd(12'hb03, 8'h00);
        for (int i = 0; i < 5; i++) u_nvcsu_nv_model.mem[i] = 8'hc0 + 8'(i);
        err_at <= 10'h002;
        nv_boot_pin <= 1'b0;
        n_commit = 0;
        wr(12'hb02, 8'h03);
        chk("soft_reset_stb", 8'h01, soft_reset_stb);
        @(posedge core_clk);
        #1 chk("soft_reset_stb", 8'h00, soft_reset_stb);
        for (int i = 0; i < 3000 && nv_load_req !== 1'b0; i++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        #1 chk("n_commit", 8'h01, 8'(n_commit));
        for (int i = 0; i < 6; i++) chk("bank", (i < 5) ? 8'hc0 + 8'(i) : 8'(21 * 7 + 3), u_nvcsu_nv_model.bank[16 + i]);
        rd(12'hb01, 8'h01);
        rd(12'hb00, 8'h00);
        rd(12'hb02, 8'h01);
        end_sim();
    end
endmodule // test_nvcsu_core
`default_nettype wire
